/* rtl/tws_defs.vh */
/*
 * Constants for the two-wire slave control block: register offsets,
 * field positions, reset values and enable code.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef TWS_DEFS_VH
`define TWS_DEFS_VH
// ****************************************************************
// Register offsets
// ****************************************************************
`define TWS_OFF_STOP 12'h014
`define TWS_OFF_SUSPEND 12'h01c
`define TWS_OFF_RESUME 12'h020
`define TWS_OFF_ARM_RX 12'h030
`define TWS_OFF_ARM_TX 12'h034
`define TWS_OFF_EV_HALTED 12'h104
`define TWS_OFF_EV_FAULT 12'h124
`define TWS_OFF_EV_RXBEGUN 12'h14c
`define TWS_OFF_EV_TXBEGUN 12'h150
`define TWS_OFF_EV_WRITE 12'h164
`define TWS_OFF_EV_READ 12'h168
`define TWS_OFF_LINKS 12'h200
`define TWS_OFF_IRQ_EN 12'h300
`define TWS_OFF_IRQ_SET 12'h304
`define TWS_OFF_IRQ_CLR 12'h308
`define TWS_OFF_FAULT_CAUSE 12'h4d0
`define TWS_OFF_HIT 12'h4d4
`define TWS_OFF_ENABLE 12'h500
`define TWS_OFF_PSEL_CLK 12'h508
`define TWS_OFF_PSEL_DAT 12'h50c
`define TWS_OFF_RX_PTR 12'h534
`define TWS_OFF_RX_LIMIT 12'h538
`define TWS_OFF_RX_TOTAL 12'h53c
`define TWS_OFF_RX_LIST 12'h540
`define TWS_OFF_TX_PTR 12'h544
`define TWS_OFF_TX_LIMIT 12'h548
`define TWS_OFF_TX_TOTAL 12'h54c
`define TWS_OFF_TX_LIST 12'h550
`define TWS_OFF_ADDR0 12'h588
`define TWS_OFF_ADDR1 12'h58c
`define TWS_OFF_MATCH_CFG 12'h594
`define TWS_OFF_FILL 12'h5c0
// ****************************************************************
// Fields and values
// ****************************************************************
`define TWS_EN_CODE 4'h9
`define TWS_PSEL_RESET 32'hffffffff
`define TWS_PSEL_CONN_BIT 31
`define TWS_IRQ_HALTED 1
`define TWS_IRQ_FAULT 9
`define TWS_IRQ_RXB 19
`define TWS_IRQ_TXB 20
`define TWS_IRQ_WRITE 25
`define TWS_IRQ_READ 26
`define TWS_IRQ_MASK 32'h06180202
`define TWS_CAUSE_OVERFLOW 0
`define TWS_CAUSE_DNACK 2
`define TWS_CAUSE_OVERREAD 3
`define TWS_CAUSE_MASK 32'h0000000d
`define TWS_CNT_W 10
`define TWS_NPINS 32
`endif

/* rtl/tws_flag.v */
/*
 * One event flag: set by a hardware pulse, loaded from data bit 0 by a software write.
 * Assumes set and clear pulses on the same clock.
 */
`timescale 1ns/1ps
module tws_flag (
   input wire clock,
   input wire rst_n,
   input wire set_pulse,
   input wire clr_wr,
   input wire clr_val,
   output reg flag_ff
);
   // A set arriving with the clear wins so no event is lost.
   wire nxt_flag = set_pulse ? 1'b1 : (clr_wr ? clr_val : flag_ff);
   always @(posedge clock) begin
      if (!rst_n)
         flag_ff <= 1'b0;
      else
         flag_ff <= nxt_flag;
   end
endmodule // tws_flag

/* rtl/tws_regs.v */
/*
 * Register file, task triggers, event flags and pin routing of a two-wire
 * slave. The bit-level protocol engine and the buffer mover sit outside and
 * join through the core_ ports. Registers are reached over a plain strobe
 * port with read data one cycle after the read strobe.
 */
// Contract
// - Clock and data lines are routed to pins named by selects.
// - Pin selects act only while enabled; kept while powered.
// - Disabled slave leaves pins to general-purpose output and setup.
// - Writing one to stop task stops the current transaction.
// - Resume task resumes; suspend task suspends the transaction.
// - Arm-receive task arms slave to accept a master write.
// - Arm-transmit task arms slave to answer a master read.
// - Event registers read one after their event; software clears them.
// - Write and read events trigger suspend when link bits set.
// - Interrupt enable register holds one bit per event, reset zero.
// - Status register shows which slave address matched.
// - Fill byte is sent when master reads past the buffer.
// - Two address registers and a config control address matching.
// - Byte totals record bytes moved in last transfer each way.
// - Buffer limits bound bytes moved to or from each buffer.
// - Slave operates only when enable field holds nine.
// - Set and clear registers alter enables on ones; reads show state.
// - Command before arming holds bus clock low until armed.
`timescale 1ns/1ps
`include "tws_defs.vh"
module tws_regs (
   input wire clock,
   input wire rst_n,
   input wire [11:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata_ff,
   output wire slave_on,
   output reg stop_pulse,
   output reg suspend_pulse,
   output reg resume_pulse,
   output reg rx_armed_ff,
   output reg tx_armed_ff,
   output wire hold_clock_low,
   output wire [5:0] irq_enables,
   input wire core_halted,
   input wire core_fault,
   input wire [2:0] core_fault_cause,
   input wire core_rx_begun,
   input wire core_tx_begun,
   input wire core_write_cmd,
   input wire core_read_cmd,
   input wire core_cmd_pending_rx,
   input wire core_cmd_pending_tx,
   input wire core_hit_valid,
   input wire core_hit_index,
   input wire core_rx_done,
   input wire [9:0] core_rx_count,
   input wire core_tx_done,
   input wire [9:0] core_tx_count,
   output reg [31:0] rx_ptr_ff,
   output reg [9:0] rx_limit_ff,
   output reg [31:0] tx_ptr_ff,
   output reg [9:0] tx_limit_ff,
   output reg [31:0] addr0_ff,
   output reg [31:0] addr1_ff,
   output reg [31:0] match_cfg_ff,
   output reg [7:0] fill_byte_ff,
   input wire core_scl_oe,
   input wire core_sda_oe,
   output wire core_scl_in,
   output wire core_sda_in,
   input wire [31:0] pin_in,
   input wire [31:0] gpio_out,
   input wire [31:0] gpio_oe,
   output reg [31:0] pin_out,
   output reg [31:0] pin_oe
);
   // ****************************************************************
   // Storage
   // ****************************************************************
   reg [3:0] enable_ff;
   reg [1:0] links_ff;
   reg [31:0] irq_en_ff;
   reg [31:0] cause_ff;
   reg hit_ff;
   reg [31:0] psel_clk_ff;
   reg [31:0] psel_dat_ff;
   reg [9:0] rx_total_ff;
   reg [9:0] tx_total_ff;
   reg [1:0] rx_list_ff;
   reg [1:0] tx_list_ff;
   reg [31:0] pin_s1_ff;
   reg [31:0] pin_s2_ff;
   wire [5:0] ev_flags;
   wire [5:0] ev_set;
   wire [11:0] ev_off [0:5];
   wire [31:0] nxt_cause;
   wire wr_one = reg_wr & reg_wdata[0];
   assign slave_on = (enable_ff == `TWS_EN_CODE);
   assign irq_enables = {irq_en_ff[`TWS_IRQ_READ], irq_en_ff[`TWS_IRQ_WRITE],
                         irq_en_ff[`TWS_IRQ_TXB], irq_en_ff[`TWS_IRQ_RXB],
                         irq_en_ff[`TWS_IRQ_FAULT], irq_en_ff[`TWS_IRQ_HALTED]};
   // ****************************************************************
   // Event flags
   // ****************************************************************
   assign ev_set = {core_read_cmd, core_write_cmd, core_tx_begun, core_rx_begun,
                    core_fault, core_halted};
   assign ev_off[0] = `TWS_OFF_EV_HALTED;
   assign ev_off[1] = `TWS_OFF_EV_FAULT;
   assign ev_off[2] = `TWS_OFF_EV_RXBEGUN;
   assign ev_off[3] = `TWS_OFF_EV_TXBEGUN;
   assign ev_off[4] = `TWS_OFF_EV_WRITE;
   assign ev_off[5] = `TWS_OFF_EV_READ;
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi = gi + 1) begin : g_ev
         tws_flag u_flag (
            .clock(clock),
            .rst_n(rst_n),
            .set_pulse(ev_set[gi]),
            .clr_wr(reg_wr && (reg_addr == ev_off[gi])),
            .clr_val(reg_wdata[0]),
            .flag_ff(ev_flags[gi])
         );
      end
   endgenerate
   // fault causes, hardware set wins over software clear
   assign nxt_cause = ((reg_wr && (reg_addr == `TWS_OFF_FAULT_CAUSE)) ?
                       (cause_ff & ~reg_wdata) : cause_ff) |
                      {28'h0000000, core_fault_cause[2], core_fault_cause[1], 1'b0,
                       core_fault_cause[0]};
   // ****************************************************************
   // Tasks and arming
   // ****************************************************************
   always @(posedge clock) begin
      if (!rst_n) begin
         stop_pulse <= 1'b0;
         suspend_pulse <= 1'b0;
         resume_pulse <= 1'b0;
         rx_armed_ff <= 1'b0;
         tx_armed_ff <= 1'b0;
      end else begin
         stop_pulse <= wr_one && (reg_addr == `TWS_OFF_STOP);
         suspend_pulse <= (wr_one && (reg_addr == `TWS_OFF_SUSPEND)) ||
                          (links_ff[0] & core_write_cmd) || (links_ff[1] & core_read_cmd);
         resume_pulse <= wr_one && (reg_addr == `TWS_OFF_RESUME);
         // arm receive; cleared when receive begins or stop ends it
         if (wr_one && (reg_addr == `TWS_OFF_ARM_RX))
            rx_armed_ff <= 1'b1;
         else if (core_rx_begun || core_halted)
            rx_armed_ff <= 1'b0;
         if (wr_one && (reg_addr == `TWS_OFF_ARM_TX))
            tx_armed_ff <= 1'b1;
         else if (core_tx_begun || core_halted)
            tx_armed_ff <= 1'b0;
      end
   end
   assign hold_clock_low = slave_on && ((core_cmd_pending_rx && !rx_armed_ff) ||
                                        (core_cmd_pending_tx && !tx_armed_ff));
   // ****************************************************************
   // Configuration writes and status capture
   // ****************************************************************
   always @(posedge clock) begin
      if (!rst_n) begin
         enable_ff <= 4'h0;
         links_ff <= 2'b00;
         irq_en_ff <= 32'h00000000;
         cause_ff <= 32'h00000000;
         hit_ff <= 1'b0;
         psel_clk_ff <= `TWS_PSEL_RESET;
         psel_dat_ff <= `TWS_PSEL_RESET;
         rx_ptr_ff <= 32'h00000000;
         rx_limit_ff <= 10'h000;
         rx_total_ff <= 10'h000;
         rx_list_ff <= 2'b00;
         tx_ptr_ff <= 32'h00000000;
         tx_limit_ff <= 10'h000;
         tx_total_ff <= 10'h000;
         tx_list_ff <= 2'b00;
         addr0_ff <= 32'h00000000;
         addr1_ff <= 32'h00000000;
         match_cfg_ff <= 32'h00000000;
         fill_byte_ff <= 8'h00;
      end else begin
         cause_ff <= nxt_cause;
         if (core_hit_valid)
            hit_ff <= core_hit_index;
         if (core_rx_done)
            rx_total_ff <= core_rx_count;
         if (core_tx_done)
            tx_total_ff <= core_tx_count;
         if (reg_wr) begin
            if (reg_addr == `TWS_OFF_ENABLE)
               enable_ff <= reg_wdata[3:0];
            else if (reg_addr == `TWS_OFF_LINKS)
               links_ff <= reg_wdata[20:19];
            else if (reg_addr == `TWS_OFF_IRQ_EN)
               irq_en_ff <= reg_wdata & `TWS_IRQ_MASK;
            else if (reg_addr == `TWS_OFF_IRQ_SET)
               irq_en_ff <= irq_en_ff | (reg_wdata & `TWS_IRQ_MASK);
            else if (reg_addr == `TWS_OFF_IRQ_CLR)
               irq_en_ff <= irq_en_ff & ~(reg_wdata & `TWS_IRQ_MASK);
            else if (reg_addr == `TWS_OFF_PSEL_CLK)
               psel_clk_ff <= reg_wdata;
            else if (reg_addr == `TWS_OFF_PSEL_DAT)
               psel_dat_ff <= reg_wdata;
            else if (reg_addr == `TWS_OFF_RX_PTR)
               rx_ptr_ff <= reg_wdata;
            else if (reg_addr == `TWS_OFF_RX_LIMIT)
               rx_limit_ff <= reg_wdata[9:0];
            else if (reg_addr == `TWS_OFF_RX_LIST)
               rx_list_ff <= reg_wdata[1:0];
            else if (reg_addr == `TWS_OFF_TX_PTR)
               tx_ptr_ff <= reg_wdata;
            else if (reg_addr == `TWS_OFF_TX_LIMIT)
               tx_limit_ff <= reg_wdata[9:0];
            else if (reg_addr == `TWS_OFF_TX_LIST)
               tx_list_ff <= reg_wdata[1:0];
            else if (reg_addr == `TWS_OFF_ADDR0)
               addr0_ff <= reg_wdata;
            else if (reg_addr == `TWS_OFF_ADDR1)
               addr1_ff <= reg_wdata;
            else if (reg_addr == `TWS_OFF_MATCH_CFG)
               match_cfg_ff <= reg_wdata;
            else if (reg_addr == `TWS_OFF_FILL)
               fill_byte_ff <= reg_wdata[7:0];
         end
      end
   end
   // ****************************************************************
   // Read port
   // ****************************************************************
   always @(posedge clock) begin
      if (!rst_n)
         reg_rdata_ff <= 32'h00000000;
      else if (reg_rd) begin
         if (reg_addr == ev_off[0])
            reg_rdata_ff <= {31'h00000000, ev_flags[0]};
         else if (reg_addr == ev_off[1])
            reg_rdata_ff <= {31'h00000000, ev_flags[1]};
         else if (reg_addr == ev_off[2])
            reg_rdata_ff <= {31'h00000000, ev_flags[2]};
         else if (reg_addr == ev_off[3])
            reg_rdata_ff <= {31'h00000000, ev_flags[3]};
         else if (reg_addr == ev_off[4])
            reg_rdata_ff <= {31'h00000000, ev_flags[4]};
         else if (reg_addr == ev_off[5])
            reg_rdata_ff <= {31'h00000000, ev_flags[5]};
         else if (reg_addr == `TWS_OFF_LINKS)
            reg_rdata_ff <= {11'h000, links_ff, 19'h00000};
         else if ((reg_addr == `TWS_OFF_IRQ_EN) || (reg_addr == `TWS_OFF_IRQ_SET) ||
                  (reg_addr == `TWS_OFF_IRQ_CLR))
            reg_rdata_ff <= irq_en_ff;
         else if (reg_addr == `TWS_OFF_FAULT_CAUSE)
            reg_rdata_ff <= cause_ff & `TWS_CAUSE_MASK;
         else if (reg_addr == `TWS_OFF_HIT)
            reg_rdata_ff <= {31'h00000000, hit_ff};
         else if (reg_addr == `TWS_OFF_ENABLE)
            reg_rdata_ff <= {28'h0000000, enable_ff};
         else if (reg_addr == `TWS_OFF_PSEL_CLK)
            reg_rdata_ff <= psel_clk_ff;
         else if (reg_addr == `TWS_OFF_PSEL_DAT)
            reg_rdata_ff <= psel_dat_ff;
         else if (reg_addr == `TWS_OFF_RX_PTR)
            reg_rdata_ff <= rx_ptr_ff;
         else if (reg_addr == `TWS_OFF_RX_LIMIT)
            reg_rdata_ff <= {22'h000000, rx_limit_ff};
         else if (reg_addr == `TWS_OFF_RX_TOTAL)
            reg_rdata_ff <= {22'h000000, rx_total_ff};
         else if (reg_addr == `TWS_OFF_RX_LIST)
            reg_rdata_ff <= {30'h00000000, rx_list_ff};
         else if (reg_addr == `TWS_OFF_TX_PTR)
            reg_rdata_ff <= tx_ptr_ff;
         else if (reg_addr == `TWS_OFF_TX_LIMIT)
            reg_rdata_ff <= {22'h000000, tx_limit_ff};
         else if (reg_addr == `TWS_OFF_TX_TOTAL)
            reg_rdata_ff <= {22'h000000, tx_total_ff};
         else if (reg_addr == `TWS_OFF_TX_LIST)
            reg_rdata_ff <= {30'h00000000, tx_list_ff};
         else if (reg_addr == `TWS_OFF_ADDR0)
            reg_rdata_ff <= addr0_ff;
         else if (reg_addr == `TWS_OFF_ADDR1)
            reg_rdata_ff <= addr1_ff;
         else if (reg_addr == `TWS_OFF_MATCH_CFG)
            reg_rdata_ff <= match_cfg_ff;
         else if (reg_addr == `TWS_OFF_FILL)
            reg_rdata_ff <= {24'h000000, fill_byte_ff};
         else
            // Task registers are write-only and unmapped offsets read zero.
            reg_rdata_ff <= 32'h00000000;
      end else
         reg_rdata_ff <= 32'h00000000;
   end
   // ****************************************************************
   // Pin routing
   // ****************************************************************
   // Pins are synchronised before the selected one reaches the protocol engine.
   always @(posedge clock) begin
      if (!rst_n) begin
         pin_s1_ff <= 32'hffffffff;
         pin_s2_ff <= 32'hffffffff;
      end else begin
         pin_s1_ff <= pin_in;
         pin_s2_ff <= pin_s1_ff;
      end
   end
   wire clk_conn = slave_on && !psel_clk_ff[`TWS_PSEL_CONN_BIT];
   wire dat_conn = slave_on && !psel_dat_ff[`TWS_PSEL_CONN_BIT];
   // selected pins, idle high when unrouted
   assign core_scl_in = clk_conn ? pin_s2_ff[psel_clk_ff[4:0]] : 1'b1;
   assign core_sda_in = dat_conn ? pin_s2_ff[psel_dat_ff[4:0]] : 1'b1;
   integer pi;
   always @* begin
      pin_out = gpio_out;
      pin_oe = gpio_oe;
      for (pi = 0; pi < `TWS_NPINS; pi = pi + 1) begin
         if (clk_conn && (psel_clk_ff[4:0] == pi[4:0])) begin
            pin_out[pi] = 1'b0;
            pin_oe[pi] = core_scl_oe | hold_clock_low;
         end else if (dat_conn && (psel_dat_ff[4:0] == pi[4:0])) begin
            pin_out[pi] = 1'b0;
            pin_oe[pi] = core_sda_oe;
         end
      end
   end
endmodule // tws_regs

/* verification/tws_regs_checker.sv */
/*
 * Port checker for the two-wire slave register block.
 * Assumes one clock and a synchronous active-low reset; bound from the bench.
 */
`timescale 1ns/1ps
module tws_regs_checker (
   input wire clock,
   input wire rst_n,
   input wire [11:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [31:0] reg_rdata_ff,
   input wire slave_on,
   input wire stop_pulse,
   input wire suspend_pulse,
   input wire resume_pulse,
   input wire rx_armed_ff,
   input wire hold_clock_low,
   input wire [5:0] irq_enables,
   input wire core_halted,
   input wire core_rx_begun,
   input wire core_tx_begun,
   input wire core_write_cmd,
   input wire core_read_cmd,
   input wire [31:0] gpio_out,
   input wire [31:0] gpio_oe,
   input wire [31:0] pin_out,
   input wire [31:0] pin_oe
);
   // ****************************************************************
   // Properties
   // ****************************************************************
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   wire wr_stop = reg_wr && reg_addr == 12'h014 && reg_wdata[0];
   wire wr_susp = reg_wr && reg_addr == 12'h01c && reg_wdata[0];
   wire wr_res = reg_wr && reg_addr == 12'h020 && reg_wdata[0];
   wire wr_arm = reg_wr && reg_addr == 12'h030 && reg_wdata[0];
   rdata_idle_a: assert property (
      !$past(reg_rd) |-> reg_rdata_ff == 32'h0) else $error("read data outside slot");
   task_read_a: assert property (
      $past(reg_rd && reg_addr[11:8] == 4'h0) |-> reg_rdata_ff == 32'h0) else $error("task read");
   stop_pulse_a: assert property (
      wr_stop |=> stop_pulse ##1 !stop_pulse) else $error("stop pulse shape");
   stop_cause_a: assert property (
      stop_pulse |-> $past(wr_stop)) else $error("stop pulse without trigger");
   resume_pulse_a: assert property (
      wr_res |=> resume_pulse) else $error("resume pulse missing");
   suspend_cause_a: assert property (
      suspend_pulse |-> $past(wr_susp || core_write_cmd || core_read_cmd))
      else $error("suspend pulse without cause");
   arm_set_a: assert property (
      wr_arm |=> rx_armed_ff) else $error("receive arm not set");
   arm_clear_a: assert property (
      $fell(rx_armed_ff) && $past(rst_n) |-> $past(core_rx_begun || core_tx_begun || core_halted))
      else $error("receive arm dropped");
   enable_rise_a: assert property (
      $rose(slave_on) |-> $past(reg_wr && reg_addr == 12'h500 && reg_wdata[3:0] == 4'h9))
      else $error("enabled without code");
   gpio_fallback_a: assert property (
      !slave_on |-> pin_out == gpio_out && pin_oe == gpio_oe) else $error("pins not gpio");
   hold_enabled_a: assert property (
      hold_clock_low |-> slave_on) else $error("stretch while disabled");
   irq_change_a: assert property (
      $changed(irq_enables) && $past(rst_n) |-> $past(reg_wr && reg_addr[11:4] == 8'h30))
      else $error("irq enables changed alone");
endmodule // tws_regs_checker

/* verification/tws_engine_model.sv */
/*
 * Far side model: protocol engine pulses and an open-drain pin bus with pull-ups.
 * Assumes the bench calls fire() and drives ext_low for the outside master.
 */
`timescale 1ns/1ps
module tws_engine_model (
   input wire clock,
   input wire [31:0] pin_out,
   input wire [31:0] pin_oe,
   input wire [31:0] ext_low,
   output wire [31:0] pin_in,
   output reg [8:0] ev_ff,
   output reg [2:0] cause_ff,
   output reg [9:0] val_ff
);
   assign pin_in = ~((pin_oe & ~pin_out) | ext_low);
   initial begin
      ev_ff = 9'h0;
      cause_ff = 3'h0;
      val_ff = 10'h0;
   end
   // Random latency keeps the block honest about waiting for real events.
   task fire(input [8:0] m, input [2:0] c, input [9:0] v);
      repeat ($urandom_range(0, 3)) @(posedge clock);
      @(posedge clock);
      ev_ff <= m;
      cause_ff <= c;
      val_ff <= v;
      @(posedge clock);
      ev_ff <= 9'h0;
      cause_ff <= 3'h0;
   endtask
endmodule // tws_engine_model

/* verification/test_i2c_slave_task_event_regs.sv */
/*
 * Self-checking bench for the two-wire slave register block with a register model.
 * Assumes the engine model file and the checker are compiled first.
 */
`timescale 1ns/1ps
module test_i2c_slave_task_event_regs;
   reg clock;
   reg rst_n;
   reg reg_wr;
   reg reg_rd;
   reg [11:0] reg_addr;
   reg [31:0] reg_wdata, gpio_out, gpio_oe, ext_low, d;
   reg [1:0] eng_oe, pend;
   wire [31:0] reg_rdata_ff, rx_ptr_ff, tx_ptr_ff, addr0_ff, addr1_ff, match_cfg_ff;
   wire [31:0] pin_out, pin_oe, pin_in;
   wire [9:0] rx_limit_ff, tx_limit_ff, val;
   wire [8:0] ev;
   wire [7:0] fill_byte_ff;
   wire [5:0] irq_enables;
   wire [2:0] cause;
   wire slave_on, stop_pulse, suspend_pulse, resume_pulse, rx_armed_ff, tx_armed_ff;
   wire hold_clock_low, core_scl_in, core_sda_in;
   bit [31:0] mdl [0:4095];
   int err_total, checked, i, k;
   logic [11:0] evo [6] = '{12'h104, 12'h124, 12'h14c, 12'h150, 12'h164, 12'h168};
   logic [11:0] tk [3] = '{12'h014, 12'h01c, 12'h020};
   logic [11:0] rw [21] = '{12'h104, 12'h124, 12'h14c, 12'h150, 12'h164, 12'h168, 12'h200,
      12'h300, 12'h304, 12'h308, 12'h4d0, 12'h534, 12'h538, 12'h544, 12'h548, 12'h588,
      12'h58c, 12'h594, 12'h5c0, 12'h540, 12'h550};
   tws_regs dut_u (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff,
      .slave_on, .stop_pulse, .suspend_pulse, .resume_pulse, .rx_armed_ff, .tx_armed_ff,
      .hold_clock_low, .irq_enables, .core_halted(ev[0]), .core_fault(ev[1]),
      .core_fault_cause(cause), .core_rx_begun(ev[2]), .core_tx_begun(ev[3]),
      .core_write_cmd(ev[4]), .core_read_cmd(ev[5]), .core_cmd_pending_rx(pend[0]),
      .core_cmd_pending_tx(pend[1]), .core_hit_valid(ev[6]), .core_hit_index(val[0]),
      .core_rx_done(ev[7]), .core_rx_count(val), .core_tx_done(ev[8]), .core_tx_count(val),
      .rx_ptr_ff, .rx_limit_ff, .tx_ptr_ff, .tx_limit_ff, .addr0_ff, .addr1_ff, .match_cfg_ff,
      .fill_byte_ff, .core_scl_oe(eng_oe[0]), .core_sda_oe(eng_oe[1]), .core_scl_in,
      .core_sda_in, .pin_in, .gpio_out, .gpio_oe, .pin_out, .pin_oe);
   tws_engine_model eng_u (.clock, .pin_out, .pin_oe, .ext_low, .pin_in, .ev_ff(ev),
      .cause_ff(cause), .val_ff(val));
   // ****************************************************************
   // Register model and bus tasks
   // ****************************************************************
   function automatic bit [31:0] msk(input [11:0] a);
      case (a)
         12'h104, 12'h124, 12'h14c, 12'h150, 12'h164, 12'h168: msk = 32'h1;
         12'h200: msk = 32'h00180000;
         12'h300: msk = 32'h06180202;
         12'h500: msk = 32'hf;
         12'h538, 12'h548: msk = 32'h3ff;
         12'h5c0: msk = 32'hff;
         12'h540, 12'h550: msk = 32'h3;
         12'h508, 12'h50c, 12'h534, 12'h544, 12'h588, 12'h58c, 12'h594: msk = 32'hffffffff;
         default: msk = 32'h0;
      endcase
   endfunction
   task chk(input [31:0] got, input [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input [11:0] a, input [31:0] v);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      if (a == 12'h304) mdl[12'h300] |= v & 32'h06180202;
      else if (a == 12'h308) mdl[12'h300] &= ~v;
      else if (a == 12'h4d0) mdl[a] &= ~v;
      else mdl[a] = v & msk(a);
      #1;
   endtask
   task rd(input [11:0] a, output [31:0] q);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 q = reg_rdata_ff;
   endtask
   task rc(input [11:0] a);
      reg [31:0] got;
      rd(a, got);
      chk(got, mdl[(a == 12'h304 || a == 12'h308) ? 12'h300 : a]);
   endtask
   task ev_go(input [8:0] m, input [2:0] c, input [9:0] v);
      eng_u.fire(m, c, v);
      for (int j = 0; j < 6; j++) if (m[j]) mdl[evo[j]] = 32'h1;
      mdl[12'h4d0] |= {28'h0, c[2], c[1], 1'b0, c[0]};
      if (m[6]) mdl[12'h4d4] = {31'h0, v[0]};
      if (m[7]) mdl[12'h53c] = {22'h0, v};
      if (m[8]) mdl[12'h54c] = {22'h0, v};
      #1;
   endtask
   task sweep;
      for (i = 0; i < 32'h5c4; i += 4) rc(i[11:0]);
   endtask
   task close_out;
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   initial begin
      #400000;
      err_total++;
      close_out;
   end
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   initial begin
      rst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 12'h0;
      reg_wdata = 32'h0;
      eng_oe = 2'h0;
      pend = 2'h0;
      gpio_out = 32'h0;
      gpio_oe = 32'h0;
      ext_low = 32'h0;
      foreach (mdl[j]) mdl[j] = 32'h0;
      mdl[12'h508] = 32'hffffffff;
      mdl[12'h50c] = 32'hffffffff;
      void'($urandom(32'h6076));
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      sweep;
      foreach (rw[j]) wr(rw[j], $urandom);
      sweep;
      chk(rx_ptr_ff, mdl[12'h534]);
      chk(rx_limit_ff, mdl[12'h538]);
      chk(tx_ptr_ff, mdl[12'h544]);
      chk(tx_limit_ff, mdl[12'h548]);
      chk(addr0_ff, mdl[12'h588]);
      chk(addr1_ff, mdl[12'h58c]);
      chk(match_cfg_ff, mdl[12'h594]);
      chk(fill_byte_ff, mdl[12'h5c0]);
      d = mdl[12'h300];
      chk(irq_enables, {d[26], d[25], d[20], d[19], d[9], d[1]});
      for (k = 0; k < 3; k++) begin
         wr(tk[k], 32'h1);
         chk({stop_pulse, suspend_pulse, resume_pulse}, 3'b100 >> k);
         @(posedge clock);
         #1 chk({stop_pulse, suspend_pulse, resume_pulse}, 3'b000);
         wr(tk[k], 32'hfffffffe);
         chk({stop_pulse, suspend_pulse, resume_pulse}, 3'b000);
      end
      wr(12'h030, 32'h1);
      chk(rx_armed_ff, 1'b1);
      ev_go(9'h004, 3'h0, 10'h0);
      chk(rx_armed_ff, 1'b0);
      wr(12'h034, 32'h1);
      chk(tx_armed_ff, 1'b1);
      ev_go(9'h001, 3'h0, 10'h0);
      chk(tx_armed_ff, 1'b0);
      for (k = 0; k < 4; k++) begin
         wr(12'h200, k[0] ? 32'h00100000 : 32'h00080000);
         ev_go(k[1] ? 9'h020 : 9'h010, 3'h0, 10'h0);
         chk(suspend_pulse, k[0] == k[1]);
      end
      ev_go(9'h002, 3'h5, 10'h0);
      ev_go(9'h040, 3'h2, 10'h1);
      ev_go(9'h080, 3'h0, 10'h3ff);
      ev_go(9'h100, 3'h0, 10'h155);
      ev_go(9'h038, 3'h0, 10'h0);
      sweep;
      foreach (evo[j]) wr(evo[j], 32'h0);
      foreach (evo[j]) rc(evo[j]);
      wr(12'h308, 32'hffffffff);
      wr(12'h304, 32'h02000202);
      rc(12'h300);
      wr(12'h308, 32'h00000200);
      rc(12'h304);
      chk(irq_enables, 6'b010001);
      @(posedge clock);
      gpio_out <= $urandom;
      gpio_oe <= $urandom;
      pend <= 2'b01;
      wr(12'h508, 32'h00000003);
      wr(12'h50c, 32'h00000007);
      chk(pin_oe, gpio_oe);
      chk(hold_clock_low, 1'b0);
      wr(12'h500, 32'h8);
      chk(slave_on, 1'b0);
      wr(12'h500, 32'h9);
      chk(slave_on, 1'b1);
      chk({hold_clock_low, pin_oe[3], pin_out[3]}, 3'b110);
      wr(12'h030, 32'h1);
      chk({hold_clock_low, pin_oe[3]}, 2'b00);
      @(posedge clock);
      pend <= 2'b10;
      @(posedge clock);
      #1 chk(hold_clock_low, 1'b1);
      wr(12'h034, 32'h1);
      chk(hold_clock_low, 1'b0);
      @(posedge clock);
      eng_oe <= 2'b10;
      ext_low <= 32'h80;
      repeat (3) @(posedge clock);
      #1 chk({core_sda_in, pin_oe[7], pin_out[7], core_scl_in}, 4'b0101);
      wr(12'h014, 32'h1);
      ev_go(9'h001, 3'h0, 10'h0);
      rc(12'h104);
      wr(12'h500, 32'h0);
      chk(pin_out, gpio_out);
      chk(pin_oe, gpio_oe);
      sweep;
      close_out;
   end
endmodule // test_i2c_slave_task_event_regs
bind tws_regs tws_regs_checker chk_u (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata_ff, .slave_on, .stop_pulse, .suspend_pulse, .resume_pulse, .rx_armed_ff,
   .hold_clock_low, .irq_enables, .core_halted, .core_rx_begun, .core_tx_begun,
   .core_write_cmd, .core_read_cmd, .gpio_out, .gpio_oe, .pin_out, .pin_oe);
